// File: src/tbod_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "tbod_params.svh"

// Summary of operation
// - 0001 00df / 01df: or / and work with file, one cycle, zero flag only
// - 0001 10df: xor work with file, one cycle, zero flag only
// - 0010 11df: decrement file, skip on zero, no flags, skip adds cycle
// - 0011 11df: increment file, skip on zero, no flags, skip adds cycle
// - 0011 01df: rotate file left through carry, one cycle, carry only
// - 0011 00df: rotate file right through carry, one cycle, carry only
// - 0110 bbbf: test bit, skip when clear, no flags, skip adds cycle
// - 0111 bbbf: test bit, skip when set, no flags changed
// - 1101 literal: or literal into work, one cycle, zero flag
// - 1111 literal: xor literal into work, one cycle, zero flag
// - 1000 literal: return placing literal in work, two cycles, no flags
// - Word 0000 0000 0011 enters standby, one cycle, time-out and power-down
// - Direction load of file 5/6/7 copies work into port A/B/C latches
// - Any program counter write except branch clears its ninth bit
// - File op writing timer count, except complement, clears prescaler if assigned there
module tbod_decoder
    import tbod_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic [7:0] work_value,
    output logic dec_valid,
    output tbod_op_t dec_op,
    output logic dest_file,
    output logic [4:0] file_addr,
    output logic [2:0] bit_sel,
    output logic [8:0] literal,
    output logic [1:0] exec_cycles,
    output logic skip_on_zero,
    output logic skip_on_clear,
    output logic skip_on_set,
    output logic upd_carry_flag,
    output logic upd_digit_carry_flag,
    output logic upd_zero_flag,
    output logic upd_time_out_flag,
    output logic upd_power_down_flag,
    output logic pc_write,
    output logic pc_bit8_clear,
    output logic prescaler_clear,
    output logic illegal_op,
    output logic [7:0] dir_latch_a,
    output logic [7:0] dir_latch_b,
    output logic [7:0] dir_latch_c,
    output logic [5:0] option_value,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    tbod_state_t s_reg;
    tbod_state_t s_next;
    logic take;
    logic addr_ph;
    logic has_d;
    logic timer_note;
    logic [31:0] rd_word;

    assign take = instr_valid && s_reg.decode_en;
    assign addr_ph = hsel && htrans[1] && hready;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[31:8] != 24'h00_0000) begin
            rd_word = 32'h0000_0000;
        end else if (haddr[7:0] == `TBOD_OFS_CTRL) begin
            rd_word[`TBOD_CTRL_EN_BIT] = s_reg.decode_en;
        end else if (haddr[7:0] == `TBOD_OFS_STATUS) begin
            rd_word[5:0] = s_reg.op;
            rd_word[`TBOD_STATUS_VALID_BIT] = s_reg.dec_valid;
            rd_word[`TBOD_STATUS_ILLEGAL_BIT] = s_reg.illegal;
        end else if (haddr[7:0] == `TBOD_OFS_DIR_A) begin
            rd_word[7:0] = s_reg.dir_a;
        end else if (haddr[7:0] == `TBOD_OFS_DIR_B) begin
            rd_word[7:0] = s_reg.dir_b;
        end else if (haddr[7:0] == `TBOD_OFS_DIR_C) begin
            rd_word[7:0] = s_reg.dir_c;
        end else if (haddr[7:0] == `TBOD_OFS_OPTION) begin
            rd_word[5:0] = s_reg.option;
        end else if (haddr[7:0] == `TBOD_OFS_COUNT) begin
            rd_word[15:0] = s_reg.instr_count;
        end
    end

    always_comb begin
        s_next = s_reg;
        has_d = 1'b0;
        timer_note = 1'b0;
        s_next.dec_valid = 1'b0;
        s_next.prescaler_clear = 1'b0;
        // Only the control word is writable; status words ignore writes
        if (s_reg.ahb_wr_pend && s_reg.ahb_addr == `TBOD_OFS_CTRL) begin
            s_next.decode_en = hwdata[`TBOD_CTRL_EN_BIT];
        end
        s_next.ahb_wr_pend = addr_ph && hwrite &&
                             hsize == `TBOD_HSIZE_WORD &&
                             haddr[31:8] == 24'h00_0000;
        if (addr_ph) begin
            s_next.ahb_addr = haddr[7:0];
        end
        if (addr_ph && !hwrite) begin
            s_next.hrdata = rd_word;
        end
        if (take) begin
            s_next.dec_valid = 1'b1;
            s_next.instr_count = s_reg.instr_count + 16'h0001;
            s_next.op = OP_ILLEGAL;
            s_next.file_addr = instr_word[4:0];
            s_next.bit_sel = instr_word[7:5];
            s_next.dest_file = 1'b0;
            s_next.literal = {1'b0, instr_word[7:0]};
            s_next.exec_cycles = `TBOD_CYCLES_ONE;
            s_next.skip_zero = 1'b0;
            s_next.skip_clear = 1'b0;
            s_next.skip_set = 1'b0;
            s_next.upd_c = 1'b0;
            s_next.upd_dc = 1'b0;
            s_next.upd_z = 1'b0;
            s_next.upd_to_pd = 1'b0;
            s_next.pc_write = 1'b0;
            // Word order matters: fixed words before wider patterns
            casez (instr_word)
                12'b0000_0000_0000: s_next.op = OP_NO_OPERATION;
                12'b0000_0000_0010: begin
                    s_next.op = OP_OPTION_LOAD;
                    s_next.option = work_value[5:0];
                end
                12'b0000_0000_0011: begin
                    s_next.op = OP_STANDBY;
                    s_next.upd_to_pd = 1'b1;
                end
                12'b0000_0000_0100: begin
                    s_next.op = OP_WATCHDOG_CLEAR;
                    s_next.upd_to_pd = 1'b1;
                end
                12'b0000_0000_0???: begin
                    if (instr_word[2:0] == `TBOD_PORT_A) begin
                        s_next.op = OP_DIRECTION_LATCH_LOAD;
                        s_next.dir_a = work_value;
                    end else if (instr_word[2:0] == `TBOD_PORT_B) begin
                        s_next.op = OP_DIRECTION_LATCH_LOAD;
                        s_next.dir_b = work_value;
                    end else if (instr_word[2:0] == `TBOD_PORT_C) begin
                        s_next.op = OP_DIRECTION_LATCH_LOAD;
                        s_next.dir_c = work_value;
                    end
                end
                12'b0000_001?_????: begin
                    s_next.op = OP_MOVE_WORK_TO_FILE;
                    s_next.dest_file = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0000_0100_0000: begin
                    s_next.op = OP_CLEAR_WORK;
                    s_next.upd_z = 1'b1;
                end
                12'b0000_011?_????: begin
                    s_next.op = OP_CLEAR_FILE;
                    s_next.dest_file = 1'b1;
                    s_next.upd_z = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0000_10??_????: begin
                    s_next.op = OP_SUB_WORK_FROM_FILE;
                    {s_next.upd_c, s_next.upd_dc, s_next.upd_z} = 3'h7;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0000_11??_????: begin
                    s_next.op = OP_DECREMENT_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0001_00??_????: begin
                    s_next.op = OP_OR_WORK_INTO_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0001_01??_????: begin
                    s_next.op = OP_AND_WORK_WITH_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0001_10??_????: begin
                    s_next.op = OP_XOR_WORK_WITH_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0001_11??_????: begin
                    s_next.op = OP_ADD_WORK_FILE;
                    {s_next.upd_c, s_next.upd_dc, s_next.upd_z} = 3'h7;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0010_00??_????: begin
                    s_next.op = OP_MOVE_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0010_01??_????: begin
                    // No prescaler side effect on this one
                    s_next.op = OP_COMPLEMENT_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                end
                12'b0010_10??_????: begin
                    s_next.op = OP_INCREMENT_FILE;
                    s_next.upd_z = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0010_11??_????: begin
                    s_next.op = OP_DECREMENT_SKIP_ZERO;
                    s_next.skip_zero = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0011_00??_????: begin
                    s_next.op = OP_ROTATE_RIGHT_FILE;
                    s_next.upd_c = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0011_01??_????: begin
                    s_next.op = OP_ROTATE_LEFT_FILE;
                    s_next.upd_c = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0011_10??_????: begin
                    s_next.op = OP_SWAP_NIBBLES;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0011_11??_????: begin
                    s_next.op = OP_INCREMENT_SKIP_ZERO;
                    s_next.skip_zero = 1'b1;
                    has_d = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0100_????_????: begin
                    s_next.op = OP_BIT_CLEAR;
                    s_next.dest_file = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0101_????_????: begin
                    s_next.op = OP_BIT_SET;
                    s_next.dest_file = 1'b1;
                    timer_note = 1'b1;
                end
                12'b0110_????_????: begin
                    s_next.op = OP_BIT_TEST_SKIP_CLEAR;
                    s_next.skip_clear = 1'b1;
                end
                12'b0111_????_????: begin
                    s_next.op = OP_BIT_TEST_SKIP_SET;
                    s_next.skip_set = 1'b1;
                end
                12'b1000_????_????: begin
                    s_next.op = OP_RETURN_WITH_LITERAL;
                    s_next.exec_cycles = `TBOD_CYCLES_TWO;
                    s_next.pc_write = 1'b1;
                end
                12'b1001_????_????: begin
                    s_next.op = OP_CALL_SUBROUTINE;
                    s_next.exec_cycles = `TBOD_CYCLES_TWO;
                    s_next.pc_write = 1'b1;
                end
                12'b101?_????_????: begin
                    s_next.op = OP_BRANCH;
                    s_next.exec_cycles = `TBOD_CYCLES_TWO;
                    s_next.pc_write = 1'b1;
                    s_next.literal = instr_word[8:0];
                end
                12'b1100_????_????: s_next.op = OP_LOAD_LITERAL;
                12'b1101_????_????: begin
                    s_next.op = OP_OR_LITERAL_INTO_WORK;
                    s_next.upd_z = 1'b1;
                end
                12'b1110_????_????: begin
                    s_next.op = OP_AND_LITERAL;
                    s_next.upd_z = 1'b1;
                end
                12'b1111_????_????: begin
                    s_next.op = OP_XOR_LITERAL_INTO_WORK;
                    s_next.upd_z = 1'b1;
                end
                default: s_next.op = OP_ILLEGAL;
            endcase
            s_next.illegal = (s_next.op == OP_ILLEGAL);
            if (has_d) begin
                s_next.dest_file = instr_word[`TBOD_D_BIT];
            end
            // A file write to the low counter byte is a counter write too
            if (s_next.dest_file && instr_word[4:0] == `TBOD_FILE_PC_LOW) begin
                s_next.pc_write = 1'b1;
            end
            s_next.pc_bit8_clear = s_next.pc_write &&
                                   s_next.op != OP_BRANCH;
            s_next.prescaler_clear = timer_note &&
                instr_word[4:0] == `TBOD_FILE_TIMER &&
                (!has_d || instr_word[`TBOD_D_BIT]) &&
                !s_reg.option[`TBOD_OPTION_PSA_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.dir_a <= `TBOD_DIR_RESET;
            s_reg.dir_b <= `TBOD_DIR_RESET;
            s_reg.dir_c <= `TBOD_DIR_RESET;
            s_reg.option <= `TBOD_OPTION_RESET;
            s_reg.decode_en <= `TBOD_CTRL_EN_RESET;
            s_reg.exec_cycles <= `TBOD_CYCLES_ONE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dec_valid = s_reg.dec_valid;
    assign dec_op = s_reg.op;
    assign dest_file = s_reg.dest_file;
    assign file_addr = s_reg.file_addr;
    assign bit_sel = s_reg.bit_sel;
    assign literal = s_reg.literal;
    assign exec_cycles = s_reg.exec_cycles;
    assign skip_on_zero = s_reg.skip_zero;
    assign skip_on_clear = s_reg.skip_clear;
    assign skip_on_set = s_reg.skip_set;
    assign upd_carry_flag = s_reg.upd_c;
    assign upd_digit_carry_flag = s_reg.upd_dc;
    assign upd_zero_flag = s_reg.upd_z;
    assign upd_time_out_flag = s_reg.upd_to_pd;
    assign upd_power_down_flag = s_reg.upd_to_pd;
    assign pc_write = s_reg.pc_write;
    assign pc_bit8_clear = s_reg.pc_bit8_clear;
    assign prescaler_clear = s_reg.prescaler_clear;
    assign illegal_op = s_reg.illegal;
    assign dir_latch_a = s_reg.dir_a;
    assign dir_latch_b = s_reg.dir_b;
    assign dir_latch_c = s_reg.dir_c;
    assign option_value = s_reg.option;
    // Zero wait states: read data is latched in the address phase
    assign hreadyout = 1'b1;
    assign hresp = `TBOD_HRESP_OKAY;
    assign hrdata = s_reg.hrdata;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence take_s(logic [11:0] mask, logic [11:0] pat);
        take && ((instr_word & mask) == pat);
    endsequence

    ior_and_a: assert property (take_s(12'hF80, 12'h100) |=>
        upd_zero_flag && !upd_carry_flag && exec_cycles == 2'h1)
        else $error("or/and decode wrong");
    xor_work_a: assert property (take_s(12'hFC0, 12'h180) |=>
        dec_op == OP_XOR_WORK_WITH_FILE && upd_zero_flag && !upd_carry_flag)
        else $error("xor work decode wrong");
    dec_skip_a: assert property (take_s(12'hFC0, 12'h2C0) |=>
        skip_on_zero && !upd_zero_flag && dec_op == OP_DECREMENT_SKIP_ZERO)
        else $error("decrement skip decode wrong");
    inc_skip_a: assert property (take_s(12'hFC0, 12'h3C0) |=>
        skip_on_zero && !upd_zero_flag && !upd_carry_flag)
        else $error("increment skip decode wrong");
    rot_left_a: assert property (take_s(12'hFC0, 12'h340) |=>
        upd_carry_flag && !upd_zero_flag && dec_op == OP_ROTATE_LEFT_FILE)
        else $error("rotate left decode wrong");
    rot_right_a: assert property (take_s(12'hFC0, 12'h300) |=>
        upd_carry_flag && !upd_digit_carry_flag && exec_cycles == 2'h1)
        else $error("rotate right decode wrong");
    bit_clear_a: assert property (take_s(12'hF00, 12'h600) |=>
        skip_on_clear && !skip_on_set && bit_sel == $past(instr_word[7:5]))
        else $error("bit test clear decode wrong");
    bit_set_a: assert property (take_s(12'hF00, 12'h700) |=>
        skip_on_set && !skip_on_clear && !upd_zero_flag)
        else $error("bit test set decode wrong");
    or_literal_a: assert property (take_s(12'hF00, 12'hD00) |=>
        upd_zero_flag && literal == {1'b0, $past(instr_word[7:0])})
        else $error("or literal decode wrong");
    xor_literal_a: assert property (take_s(12'hF00, 12'hF00) |=>
        dec_op == OP_XOR_LITERAL_INTO_WORK && upd_zero_flag)
        else $error("xor literal decode wrong");
    ret_literal_a: assert property (take_s(12'hF00, 12'h800) |=>
        exec_cycles == 2'h2 && !upd_zero_flag && pc_bit8_clear)
        else $error("return literal decode wrong");
    standby_a: assert property (take_s(12'hFFF, 12'h003) |=>
        upd_time_out_flag && upd_power_down_flag && exec_cycles == 2'h1)
        else $error("standby decode wrong");
    dir_load_a: assert property (take_s(12'hFFF, 12'h006) |=>
        dir_latch_b == $past(work_value) && $stable(dir_latch_a))
        else $error("direction latch not loaded");
    branch_keep_a: assert property (take_s(12'hE00, 12'hA00) |=>
        pc_write && !pc_bit8_clear && literal == $past(instr_word[8:0]))
        else $error("branch cleared ninth bit");
    call_clear_a: assert property (take_s(12'hF00, 12'h900) |=>
        pc_bit8_clear && exec_cycles == 2'h2)
        else $error("call did not clear ninth bit");
    // Pulse may stand again only when a new word was decoded
    presc_clear_a: assert property (take_s(12'hFFF, 12'h3E1) ##0
        !option_value[3] |=> prescaler_clear ##1
        (dec_valid || !prescaler_clear))
        else $error("prescaler clear wrong");
    dest_sel_a: assert property (take_s(12'hFC0, 12'h1C0) |=>
        dest_file == $past(instr_word[5]) &&
        file_addr == $past(instr_word[4:0]))
        else $error("destination select wrong");

endmodule : tbod_decoder
`default_nettype wire

// File: src/tbod_params.svh
`ifndef TBOD_PARAMS_SVH
`define TBOD_PARAMS_SVH

// Register byte offsets on the bus
`define TBOD_OFS_CTRL 8'h00
`define TBOD_OFS_STATUS 8'h04
`define TBOD_OFS_DIR_A 8'h08
`define TBOD_OFS_DIR_B 8'h0C
`define TBOD_OFS_DIR_C 8'h10
`define TBOD_OFS_OPTION 8'h14
`define TBOD_OFS_COUNT 8'h18

// Field positions
`define TBOD_CTRL_EN_BIT 0
`define TBOD_D_BIT 5
`define TBOD_OPTION_PSA_BIT 3
`define TBOD_STATUS_VALID_BIT 8
`define TBOD_STATUS_ILLEGAL_BIT 9

// Reset values
`define TBOD_CTRL_EN_RESET 1'h1
`define TBOD_DIR_RESET 8'hFF
`define TBOD_OPTION_RESET 6'h3F

// File numbers with side effects
`define TBOD_FILE_TIMER 5'h01
`define TBOD_FILE_PC_LOW 5'h02
`define TBOD_PORT_A 3'h5
`define TBOD_PORT_B 3'h6
`define TBOD_PORT_C 3'h7

// Instruction cycle counts
`define TBOD_CYCLES_ONE 2'h1
`define TBOD_CYCLES_TWO 2'h2
`define TBOD_SKIP_EXTRA 2'h1

// Bus encodings
`define TBOD_HSIZE_WORD 3'h2
`define TBOD_HRESP_OKAY 1'h0

`endif

// File: src/tbod_pkg.sv
package tbod_pkg;

    typedef enum logic [5:0] {
        OP_NO_OPERATION, OP_ADD_WORK_FILE, OP_AND_WORK_WITH_FILE,
        OP_CLEAR_FILE, OP_CLEAR_WORK, OP_COMPLEMENT_FILE,
        OP_DECREMENT_FILE, OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_FILE,
        OP_INCREMENT_SKIP_ZERO, OP_OR_WORK_INTO_FILE, OP_MOVE_FILE,
        OP_MOVE_WORK_TO_FILE, OP_ROTATE_LEFT_FILE, OP_ROTATE_RIGHT_FILE,
        OP_SUB_WORK_FROM_FILE, OP_SWAP_NIBBLES, OP_XOR_WORK_WITH_FILE,
        OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TEST_SKIP_CLEAR,
        OP_BIT_TEST_SKIP_SET, OP_AND_LITERAL, OP_CALL_SUBROUTINE,
        OP_WATCHDOG_CLEAR, OP_BRANCH, OP_OR_LITERAL_INTO_WORK,
        OP_LOAD_LITERAL, OP_OPTION_LOAD, OP_RETURN_WITH_LITERAL,
        OP_STANDBY, OP_DIRECTION_LATCH_LOAD, OP_XOR_LITERAL_INTO_WORK,
        OP_ILLEGAL
    } tbod_op_t;

    typedef struct packed {
        logic dec_valid;
        tbod_op_t op;
        logic dest_file;
        logic [4:0] file_addr;
        logic [2:0] bit_sel;
        logic [8:0] literal;
        logic [1:0] exec_cycles;
        logic skip_zero;
        logic skip_clear;
        logic skip_set;
        logic upd_c;
        logic upd_dc;
        logic upd_z;
        logic upd_to_pd;
        logic pc_write;
        logic pc_bit8_clear;
        logic prescaler_clear;
        logic illegal;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
        logic [5:0] option;
        logic decode_en;
        logic [15:0] instr_count;
        logic ahb_wr_pend;
        logic [7:0] ahb_addr;
        logic [31:0] hrdata;
    } tbod_state_t;

endpackage : tbod_pkg

// File: verif/tbod_prog_mem.sv
`timescale 1ns/10ps
`default_nettype none
module tbod_prog_mem (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic [11:0] word,
    input wire logic [7:0] wv,
    output logic instr_valid,
    output logic [11:0] instr_word,
    output logic [7:0] work_value
);
    // Idle fetch alternates between the complement of the last word and the last word
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            instr_valid <= 1'b0;
            instr_word <= 12'hA5A;
            work_value <= 8'h5A;
        end else begin
            instr_valid <= req;
            instr_word <= req ? word : ~instr_word;
            work_value <= req ? wv : ~work_value;
        end
    end
endmodule : tbod_prog_mem
`default_nettype wire

// File: verif/test_twelve_bit_opcode_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module test_twelve_bit_opcode_decoder
    import tbod_pkg::*;
;
    typedef struct {logic [11:0] base, msk; tbod_op_t op; logic [7:0] ex;}
        tbod_case_t;
    logic core_clk, nrst = 0, req = 0, hsel = 0, hwrite = 0, hready;
    logic [11:0] w = '0, instr_word;
    logic [7:0] wv = '0, work_value, dir_latch_a, dir_latch_b, dir_latch_c;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0, exec_cycles;
    logic [2:0] hsize = '0, bit_sel;
    logic instr_valid, dec_valid, dest_file, skip_on_zero, skip_on_clear;
    logic skip_on_set, upd_carry_flag, upd_digit_carry_flag, upd_zero_flag;
    logic upd_time_out_flag, upd_power_down_flag, pc_write, pc_bit8_clear;
    logic prescaler_clear, illegal_op, hreadyout, hresp;
    logic [4:0] file_addr;
    logic [8:0] literal;
    logic [5:0] option_value;
    tbod_op_t dec_op;
    int n_mismatch = 0, compares = 0;
    logic [31:0] seed = 32'h6FB9F234;
    tbod_case_t cs [18];
    assign hready = hreadyout;
    tbod_prog_mem mem (.core_clk, .nrst, .req, .word(w), .wv, .instr_valid,
        .instr_word, .work_value);
    tbod_decoder DUT (.core_clk, .nrst, .instr_valid, .instr_word,
        .work_value, .dec_valid, .dec_op, .dest_file, .file_addr, .bit_sel,
        .literal, .exec_cycles, .skip_on_zero, .skip_on_clear, .skip_on_set,
        .upd_carry_flag, .upd_digit_carry_flag, .upd_zero_flag,
        .upd_time_out_flag, .upd_power_down_flag, .pc_write, .pc_bit8_clear,
        .prescaler_clear, .illegal_op, .dir_latch_a, .dir_latch_b,
        .dir_latch_c, .option_value, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic dec(input logic [11:0] a, input logic [7:0] v);
        @(posedge core_clk);
        req <= 1'b1;
        w <= a;
        wv <= v;
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : dec
    task automatic bus(input logic wr, input logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        logic [11:0] x;
        logic [7:0] v;
        logic [15:0] n;
        // Expected bits: cycles, zero, carry, time-out, skip zero/clear/set
        cs = '{'{12'h100, 12'h03F, OP_OR_WORK_INTO_FILE, 8'h60},
            '{12'h140, 12'h03F, OP_AND_WORK_WITH_FILE, 8'h60},
            '{12'h180, 12'h03F, OP_XOR_WORK_WITH_FILE, 8'h60},
            '{12'h2C0, 12'h03F, OP_DECREMENT_SKIP_ZERO, 8'h44},
            '{12'h3C0, 12'h03F, OP_INCREMENT_SKIP_ZERO, 8'h44},
            '{12'h340, 12'h03F, OP_ROTATE_LEFT_FILE, 8'h50},
            '{12'h300, 12'h03F, OP_ROTATE_RIGHT_FILE, 8'h50},
            '{12'h600, 12'h0FF, OP_BIT_TEST_SKIP_CLEAR, 8'h42},
            '{12'h700, 12'h0FF, OP_BIT_TEST_SKIP_SET, 8'h41},
            '{12'hD00, 12'h0FF, OP_OR_LITERAL_INTO_WORK, 8'h60},
            '{12'hF00, 12'h0FF, OP_XOR_LITERAL_INTO_WORK, 8'h60},
            '{12'h800, 12'h0FF, OP_RETURN_WITH_LITERAL, 8'h80},
            '{12'h003, 12'h000, OP_STANDBY, 8'h48},
            '{12'hA00, 12'h1FF, OP_BRANCH, 8'h80},
            '{12'h1C0, 12'h03F, OP_ADD_WORK_FILE, 8'h70},
            '{12'h900, 12'h0FF, OP_CALL_SUBROUTINE, 8'h80},
            '{12'h004, 12'h000, OP_WATCHDOG_CLEAR, 8'h48},
            '{12'h080, 12'h03F, OP_SUB_WORK_FROM_FILE, 8'h70}};
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("dir_a", 8'hFF, dir_latch_a);
        bus(1'b0, 8'h00, 0);
        chk("ctrl", 1, rd);
        chk("hresp", 0, hresp);
        repeat (3) foreach (cs[i]) begin
            x = cs[i].base | (12'(rnd()) & cs[i].msk);
            dec(x, 8'(rnd()));
            chk("valid", 1, dec_valid);
            chk("op", {cs[i].op, cs[i].ex}, {dec_op, exec_cycles, upd_zero_flag,
                upd_carry_flag, upd_time_out_flag, skip_on_zero, skip_on_clear,
                skip_on_set});
            chk("fields", x[7:0], {bit_sel, file_addr});
            // Digit carry only where zero and carry both update
            chk("dc_pd_ill", {cs[i].ex[5] & cs[i].ex[4], cs[i].ex[3], 1'b0},
                {upd_digit_carry_flag, upd_power_down_flag,
                illegal_op});
            chk("literal", x[7:0], literal[7:0]);
            if (cs[i].msk == 12'h03F) chk("dest", x[5], dest_file);
        end
        $display("decode table test done");
        for (int p = 5; p < 8; p++) begin
            v = 8'(rnd());
            dec(12'(p), v);
            chk("latch", v, p == 5 ? dir_latch_a : p == 6 ? dir_latch_b
                : dir_latch_c);
            bus(1'b0, 8'(4 * p - 12), 0);
            chk("latch_reg", v, rd);
        end
        dec(12'h800, 8'h00);
        chk("pc", 2'b11, {pc_write, pc_bit8_clear});
        dec(12'hA3F, 8'h00);
        chk("pc", 2'b10, {pc_write, pc_bit8_clear});
        dec(12'h001, 8'h00);
        chk("illegal", 1, illegal_op);
        dec(12'h002, 8'h00);
        dec(12'h3E1, 8'h00);
        chk("psc", 1, prescaler_clear);
        dec(12'h002, 8'h08);
        chk("option", 8'h08, option_value);
        dec(12'h3E1, 8'h00);
        chk("psc", 0, prescaler_clear);
        $display("latch, counter and prescaler tests done");
        bus(1'b0, 8'h18, 0);
        n = rd[15:0];
        bus(1'b1, 8'h00, 0);
        dec(12'h100, 8'h00);
        chk("refused", 0, dec_valid);
        bus(1'b0, 8'h18, 0);
        chk("count", n, rd[15:0]);
        bus(1'b1, 8'h00, 1);
        bus(1'b0, 8'h40, 0);
        chk("unmapped", 0, rd);
        $display("bus test done");
        report_and_stop();
    end
endmodule : test_twelve_bit_opcode_decoder
`default_nettype wire
